//--- src/cpuam_pkg.sv
// Shared types and constants for the CPU addressing mode decoder
package cpuam_pkg;

	typedef enum logic [3:0] {
		AM_INHERENT,
		AM_IMMEDIATE,
		AM_DIR_SHORT,
		AM_DIR_LONG,
		AM_IDX_NONE,
		AM_IDX_SHORT,
		AM_IDX_LONG,
		AM_IND_SHORT,
		AM_IND_LONG,
		AM_INDIDX_SHORT,
		AM_INDIDX_LONG,
		AM_REL_DIRECT,
		AM_REL_INDIRECT
	} cpuam_mode_type;

	typedef enum logic [5:0] {
		nop_op, trap_op, wait_for_interrupt_op, halt_op, subroutine_return_op,
		interrupt_return_op, set_irq_mask_op, clear_irq_mask_op, set_carry_op,
		clear_carry_op, stack_pointer_reset_op, load_op, clear_op, push_op, pop_op,
		increment_op, decrement_op, zero_negative_test_op, ones_complement_op,
		twos_complement_op, byte_multiply_op, shift_left_logical_op,
		shift_right_logical_op, shift_right_arith_op, rotate_left_carry_op,
		rotate_right_carry_op, nibble_swap_op, compare_op, bit_compare_op, and_op,
		or_op, xor_op, add_carry_op, add_op, subtract_op, subtract_borrow_op,
		bit_set_op, bit_reset_op, bit_test_jump_true_op, bit_test_jump_false_op,
		call_op, absolute_jump_op, conditional_relative_jump_op, relative_call_op
	} cpuam_op_type;

	typedef enum logic [4:0] {
		ST_IDLE  = 5'b00001,
		ST_FETCH = 5'b00010,
		ST_PREAD = 5'b00100,
		ST_CALC  = 5'b01000,
		ST_DONE  = 5'b10000
	} cpuam_state_type;

	localparam logic [1:0] IRQ_LEVEL_RESET   = 2'h3;
	localparam logic [1:0] IRQ_LEVEL_MASKED  = 2'h3;
	localparam logic [1:0] IRQ_LEVEL_OPEN    = 2'h0;
	localparam logic [7:0] PAGE_ZERO_HI      = 8'h00;
	localparam logic [15:0] IDX_SHORT_LIMIT  = 16'h01FE;
	localparam logic [15:0] PTR_STEP         = 16'h0001;

endpackage : cpuam_pkg

//--- src/cpuam_decoder.sv
// Addressing mode decoder: operand byte fetch, pointer read and address forming
//
// Functional notes
// RULE1: Inherent instructions are one opcode byte; nothing is fetched after it.
// RULE2: Set-interrupt-mask raises the interrupt mask level to 3.
// RULE3: Clear-interrupt-mask lowers the interrupt mask level to 0.
// RULE4: Halt stops the oscillator; wait-for-interrupt enters low power until interrupt.
// RULE5: Inherent mode also accepts the listed register-only operations.
// RULE6: Immediate is opcode plus literal; only load, compare, logic, arithmetic.
// RULE7: Short direct fetches one address byte, reaching 00 to FF.
// RULE8: Long direct fetches a two-byte address covering 64 Kbyte.
// RULE9: Indexed address is unsigned sum of X or Y and the offset.
// RULE10: No-offset indexed fetches nothing; index alone addresses 00 to FF.
// RULE11: Short indexed fetches one offset byte; sum reaches 00 to 1FE.
// RULE12: Long indexed fetches a two-byte offset covering 64 Kbyte.
// RULE13: Indirect: byte after opcode addresses a pointer read from memory.
// RULE14: Short indirect: one pointer-address byte, one-byte pointer, 00 to FF.
// RULE15: Long indirect: one pointer-address byte, 16-bit pointer read from memory.
// RULE16: Indirect indexed address is index plus pointer read from memory.
// RULE17: Short indirect indexed reaches 00 to 1FE; long uses 16-bit pointer.
// RULE18: Full-class operations accept short and long memory forms.
// RULE19: Read-modify-write, bit, jump and call operations accept short forms only.
// RULE20: Relative mode adds a signed 8-bit offset to the program counter.
// RULE21: Relative direct offset is the byte following the opcode.
// RULE22: Relative indirect offset is read from memory at the following byte.
// RULE23: Two-byte quantities arrive most significant byte first.
`timescale 1ns/1ps

module cpuam_decoder (
	input  wire logic                  clk,
	input  wire logic                  rstn,
	input  wire logic                  clk_en,
	input  wire logic                  start,
	input  wire cpuam_pkg::cpuam_mode_type mode_in,
	input  wire cpuam_pkg::cpuam_op_type   op_in,
	input  wire logic                  use_y,
	input  wire logic [7:0]            x_reg,
	input  wire logic [7:0]            y_reg,
	input  wire logic [15:0]           next_pc,
	input  wire logic                  ibyte_valid,
	input  wire logic [7:0]            ibyte_data,
	output logic                       ibyte_ready,
	output logic                       mem_rd,
	output logic [15:0]                mem_addr,
	input  wire logic                  mem_rvalid,
	input  wire logic [7:0]            mem_rdata,
	output logic                       busy,
	output logic                       done,
	output logic                       illegal,
	output logic [1:0]                 follow_len,
	output logic [15:0]                eff_addr,
	output logic [7:0]                 imm_value,
	output logic [15:0]                branch_target,
	output logic [1:0]                 irq_level,
	output logic                       halt_pulse,
	output logic                       wait_pulse
);
	import cpuam_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Decode helpers

	function automatic logic is_inherent_op(input cpuam_op_type op);
		case (op)
			nop_op, trap_op, wait_for_interrupt_op, halt_op, subroutine_return_op,
			interrupt_return_op, set_irq_mask_op, clear_irq_mask_op, set_carry_op,
			clear_carry_op, stack_pointer_reset_op, load_op, clear_op, push_op,
			pop_op, increment_op, decrement_op, zero_negative_test_op,
			ones_complement_op, twos_complement_op, byte_multiply_op,
			shift_left_logical_op, shift_right_logical_op, shift_right_arith_op,
			rotate_left_carry_op, rotate_right_carry_op, nibble_swap_op: return 1'b1; // RULE5
			default: return 1'b0;
		endcase
	endfunction : is_inherent_op

	function automatic logic is_full_op(input cpuam_op_type op);
		case (op)
			load_op, compare_op, bit_compare_op, and_op, or_op, xor_op,
			add_carry_op, add_op, subtract_op, subtract_borrow_op: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction : is_full_op

	function automatic logic is_short_op(input cpuam_op_type op);
		case (op)
			clear_op, increment_op, decrement_op, zero_negative_test_op,
			ones_complement_op, twos_complement_op, bit_set_op, bit_reset_op,
			bit_test_jump_true_op, bit_test_jump_false_op, shift_left_logical_op,
			shift_right_logical_op, shift_right_arith_op, rotate_left_carry_op,
			rotate_right_carry_op, nibble_swap_op, call_op, absolute_jump_op: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction : is_short_op

	function automatic logic mode_allowed(input cpuam_op_type op, input cpuam_mode_type m);
		case (m)
			AM_INHERENT:  return is_inherent_op(op);
			AM_IMMEDIATE: return is_full_op(op); // RULE6
			AM_DIR_SHORT, AM_IDX_NONE, AM_IDX_SHORT, AM_IND_SHORT, AM_INDIDX_SHORT:
				return is_full_op(op) || is_short_op(op); // RULE19
			AM_DIR_LONG, AM_IDX_LONG, AM_IND_LONG, AM_INDIDX_LONG:
				return is_full_op(op); // RULE18
			AM_REL_DIRECT, AM_REL_INDIRECT:
				return (op == conditional_relative_jump_op) || (op == relative_call_op); // RULE20
			default: return 1'b0;
		endcase
	endfunction : mode_allowed

	// Bytes that follow the opcode in the instruction stream
	function automatic logic [1:0] follow_bytes(input cpuam_mode_type m);
		case (m)
			AM_INHERENT, AM_IDX_NONE: return 2'h0; // RULE1 RULE10
			AM_DIR_LONG, AM_IDX_LONG: return 2'h2; // RULE8 RULE12
			default:                  return 2'h1; // RULE7 RULE11 RULE14 RULE15 RULE21
		endcase
	endfunction : follow_bytes

	// Bytes read from memory through the pointer address
	function automatic logic [1:0] pointer_bytes(input cpuam_mode_type m);
		case (m)
			AM_IND_SHORT, AM_INDIDX_SHORT, AM_REL_INDIRECT: return 2'h1; // RULE14 RULE22
			AM_IND_LONG, AM_INDIDX_LONG:                    return 2'h2; // RULE15 RULE17
			default:                                        return 2'h0;
		endcase
	endfunction : pointer_bytes

	////////////////////////////////////////////////////////////////////////////
	// Reset release

	logic [1:0] rst_sync_r;
	logic       rst_n_s;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rst_sync_r <= 2'h0;
		end else begin
			rst_sync_r <= {rst_sync_r[0], 1'b1};
		end
	end
	assign rst_n_s = rst_sync_r[1];

	////////////////////////////////////////////////////////////////////////////
	// Sequencer

	cpuam_state_type state_r;
	cpuam_mode_type  mode_r;
	cpuam_op_type    op_r;
	logic [7:0]      idx_r;
	logic [15:0]     pc_r;
	logic [15:0]     word_r;
	logic [15:0]     ptr_r;
	logic [1:0]      left_r;
	logic            take;
	logic            ok_in;

	assign take        = clk_en && (state_r == ST_IDLE) && start;
	assign ok_in       = mode_allowed(op_in, mode_in);
	assign ibyte_ready = clk_en && (state_r == ST_FETCH);
	assign mem_rd      = clk_en && (state_r == ST_PREAD); // RULE13
	assign busy        = (state_r != ST_IDLE);
	assign done        = (state_r == ST_DONE);

	always_ff @(posedge clk or negedge rst_n_s) begin
		if (!rst_n_s) begin
			state_r <= ST_IDLE;
			left_r  <= 2'h0;
		end else if (clk_en) begin
			case (state_r)
				ST_IDLE: begin
					if (start) begin
						left_r <= follow_bytes(mode_in);
						if (!ok_in) begin
							state_r <= ST_DONE;
						end else if (follow_bytes(mode_in) == 2'h0) begin
							state_r <= ST_CALC; // RULE1
						end else begin
							state_r <= ST_FETCH;
						end
					end
				end
				ST_FETCH: begin
					if (ibyte_valid) begin
						left_r <= left_r - 2'h1;
						if (left_r == 2'h1) begin
							left_r  <= pointer_bytes(mode_r);
							state_r <= (pointer_bytes(mode_r) != 2'h0) ? ST_PREAD : ST_CALC;
						end
					end
				end
				ST_PREAD: begin
					if (mem_rvalid) begin
						left_r <= left_r - 2'h1;
						if (left_r == 2'h1) begin
							state_r <= ST_CALC;
						end
					end
				end
				ST_CALC: state_r <= ST_DONE;
				ST_DONE: state_r <= ST_IDLE;
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	// Request context, held for the whole decode
	always_ff @(posedge clk or negedge rst_n_s) begin
		if (!rst_n_s) begin
			mode_r     <= AM_INHERENT;
			op_r       <= nop_op;
			idx_r      <= 8'h00;
			pc_r       <= 16'h0000;
			illegal    <= 1'b0;
			follow_len <= 2'h0;
		end else if (take) begin
			mode_r     <= mode_in;
			op_r       <= op_in;
			idx_r      <= use_y ? y_reg : x_reg; // RULE9
			pc_r       <= next_pc;
			illegal    <= !ok_in;
			follow_len <= ok_in ? follow_bytes(mode_in) : 2'h0;
		end
	end

	// Stream and pointer bytes shift in from the low end, first byte ends high
	always_ff @(posedge clk or negedge rst_n_s) begin
		if (!rst_n_s) begin
			word_r   <= 16'h0000;
			ptr_r    <= 16'h0000;
			mem_addr <= 16'h0000;
		end else if (clk_en) begin
			if (take) begin
				word_r <= 16'h0000;
				ptr_r  <= 16'h0000;
			end
			if (ibyte_ready && ibyte_valid) begin
				word_r <= {word_r[7:0], ibyte_data}; // RULE23
				if (left_r == 2'h1) begin
					// Pointer address is one byte, so the pointer sits in page zero
					mem_addr <= {PAGE_ZERO_HI, ibyte_data}; // RULE13
				end
			end
			if (mem_rd && mem_rvalid) begin
				ptr_r    <= {ptr_r[7:0], mem_rdata}; // RULE23
				mem_addr <= mem_addr + PTR_STEP;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Address forming

	always_ff @(posedge clk or negedge rst_n_s) begin
		if (!rst_n_s) begin
			eff_addr      <= 16'h0000;
			imm_value     <= 8'h00;
			branch_target <= 16'h0000;
		end else if (clk_en && state_r == ST_CALC) begin
			case (mode_r)
				AM_IMMEDIATE:    imm_value <= word_r[7:0]; // RULE6
				AM_DIR_SHORT:    eff_addr <= {PAGE_ZERO_HI, word_r[7:0]}; // RULE7
				AM_DIR_LONG:     eff_addr <= word_r; // RULE8
				AM_IDX_NONE:     eff_addr <= {PAGE_ZERO_HI, idx_r}; // RULE10
				AM_IDX_SHORT:    eff_addr <= {PAGE_ZERO_HI, word_r[7:0]} + {PAGE_ZERO_HI, idx_r}; // RULE11
				AM_IDX_LONG:     eff_addr <= word_r + {PAGE_ZERO_HI, idx_r}; // RULE12
				AM_IND_SHORT:    eff_addr <= {PAGE_ZERO_HI, ptr_r[7:0]}; // RULE14
				AM_IND_LONG:     eff_addr <= ptr_r; // RULE15
				AM_INDIDX_SHORT: eff_addr <= {PAGE_ZERO_HI, ptr_r[7:0]} + {PAGE_ZERO_HI, idx_r}; // RULE16 RULE17
				AM_INDIDX_LONG:  eff_addr <= ptr_r + {PAGE_ZERO_HI, idx_r}; // RULE16 RULE17
				AM_REL_DIRECT:   branch_target <= pc_r + {{8{word_r[7]}}, word_r[7:0]}; // RULE20 RULE21
				AM_REL_INDIRECT: branch_target <= pc_r + {{8{ptr_r[7]}}, ptr_r[7:0]}; // RULE22
				default:         imm_value <= imm_value;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Inherent side effects

	logic inh_go;
	assign inh_go = clk_en && (state_r == ST_CALC) && (mode_r == AM_INHERENT);

	always_ff @(posedge clk or negedge rst_n_s) begin
		if (!rst_n_s) begin
			irq_level <= IRQ_LEVEL_RESET;
		end else if (inh_go && op_r == set_irq_mask_op) begin
			irq_level <= IRQ_LEVEL_MASKED; // RULE2
		end else if (inh_go && op_r == clear_irq_mask_op) begin
			irq_level <= IRQ_LEVEL_OPEN; // RULE3
		end
	end

	// Pulses line up with done so the power controller sees one request
	always_ff @(posedge clk or negedge rst_n_s) begin
		if (!rst_n_s) begin
			halt_pulse <= 1'b0;
			wait_pulse <= 1'b0;
		end else if (clk_en) begin
			halt_pulse <= inh_go && (op_r == halt_op); // RULE4
			wait_pulse <= inh_go && (op_r == wait_for_interrupt_op); // RULE4
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks

	property p_inh_len;
		@(posedge clk) disable iff (!rst_n_s)
		(done && !illegal && mode_r == AM_INHERENT) |-> (follow_len == 2'h0);
	endproperty
	a_inh_len: assert property (p_inh_len) else $error("inherent length not zero"); // RULE1

	property p_sim;
		@(posedge clk) disable iff (!rst_n_s)
		(done && !illegal && mode_r == AM_INHERENT && op_r == set_irq_mask_op)
			|-> irq_level == 2'h3;
	endproperty
	a_sim: assert property (p_sim) else $error("mask not raised to 3"); // RULE2

	property p_rim;
		@(posedge clk) disable iff (!rst_n_s)
		(done && !illegal && mode_r == AM_INHERENT && op_r == clear_irq_mask_op)
			|-> irq_level == 2'h0;
	endproperty
	a_rim: assert property (p_rim) else $error("mask not lowered to 0"); // RULE3

	property p_halt;
		@(posedge clk) disable iff (!rst_n_s)
		halt_pulse |-> (done && op_r == halt_op && mode_r == AM_INHERENT);
	endproperty
	a_halt: assert property (p_halt) else $error("halt pulse without halt"); // RULE4

	property p_imm;
		@(posedge clk) disable iff (!rst_n_s)
		(done && !illegal && mode_r == AM_IMMEDIATE) |-> (follow_len == 2'h1 && imm_value == word_r[7:0]);
	endproperty
	a_imm: assert property (p_imm) else $error("immediate operand wrong"); // RULE6

	property p_idx_short;
		@(posedge clk) disable iff (!rst_n_s)
		(done && !illegal && mode_r == AM_IDX_SHORT)
			|-> (eff_addr == word_r[7:0] + idx_r && eff_addr <= 16'h01FE);
	endproperty
	a_idx_short: assert property (p_idx_short) else $error("short indexed address wrong"); // RULE11

	property p_idx_long;
		@(posedge clk) disable iff (!rst_n_s)
		(done && !illegal && mode_r == AM_IDX_LONG) |-> eff_addr == 16'(word_r + idx_r);
	endproperty
	a_idx_long: assert property (p_idx_long) else $error("long indexed address wrong"); // RULE9

	property p_ptr_only_indirect;
		@(posedge clk) disable iff (!rst_n_s)
		mem_rd |-> (pointer_bytes(mode_r) != 2'h0 && $past(state_r) != ST_IDLE);
	endproperty
	a_ptr_only_indirect: assert property (p_ptr_only_indirect) else $error("pointer read in wrong mode"); // RULE13

	property p_rel;
		@(posedge clk) disable iff (!rst_n_s)
		(done && !illegal && mode_r == AM_REL_DIRECT)
			|-> branch_target == 16'(pc_r + {{8{word_r[7]}}, word_r[7:0]});
	endproperty
	a_rel: assert property (p_rel) else $error("relative target wrong"); // RULE21

	property p_long_short_only;
		@(posedge clk) disable iff (!rst_n_s)
		(take && is_short_op(op_in) && !is_full_op(op_in) && mode_in == AM_DIR_LONG)
			|=> (illegal && done);
	endproperty
	a_long_short_only: assert property (p_long_short_only) else $error("long form accepted"); // RULE19

endmodule : cpuam_decoder

//--- test/test_cpu_addressing_mode_decoder.sv
// Self-checking bench for the addressing mode decoder
`timescale 1ns/1ps

module test_cpu_addressing_mode_decoder;
	import cpuam_pkg::*;

	logic           clk, rstn, clk_en, start, use_y, ibyte_valid, mem_rvalid;
	cpuam_mode_type mode_in;
	cpuam_op_type   op_in;
	logic [7:0]     x_reg, y_reg, ibyte_data, mem_rdata;
	logic [15:0]    next_pc, mem_addr, eff_addr, branch_target;
	logic           ibyte_ready, mem_rd, busy, done, illegal, halt_pulse, wait_pulse;
	logic [1:0]     follow_len, irq_level, exp_irq;
	logic [7:0]     imm_value, nb, nr;
	logic [15:0]    rd_addr [0:3];
	int             seed, n_mismatch, checks, ntest;

	cpuam_decoder dut (.clk(clk), .rstn(rstn), .clk_en(clk_en), .start(start),
		.mode_in(mode_in), .op_in(op_in), .use_y(use_y), .x_reg(x_reg), .y_reg(y_reg),
		.next_pc(next_pc), .ibyte_valid(ibyte_valid), .ibyte_data(ibyte_data),
		.ibyte_ready(ibyte_ready), .mem_rd(mem_rd), .mem_addr(mem_addr),
		.mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata), .busy(busy), .done(done),
		.illegal(illegal), .follow_len(follow_len), .eff_addr(eff_addr),
		.imm_value(imm_value), .branch_target(branch_target), .irq_level(irq_level),
		.halt_pulse(halt_pulse), .wait_pulse(wait_pulse));

	always #2.5 clk = ~clk;

	// Handshake bookkeeping at the sampling edge
	always @(posedge clk) begin
		if (ibyte_ready && ibyte_valid)
			nb <= nb + 8'h01;
		if (mem_rd && mem_rvalid) begin
			rd_addr[nr[1:0]] <= mem_addr;
			nr <= nr + 8'h01;
		end
	end

	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : end_sim

	// Memory contents: address dependent so swapped bytes show up
	function automatic logic [7:0] mem_fn(input logic [15:0] a);
		return {a[3:0], a[7:4]} ^ a[15:8] ^ 8'h5A;
	endfunction : mem_fn

	function automatic logic legal(input cpuam_mode_type m, input cpuam_op_type o);
		logic full, shrt;
		full = o inside {load_op, compare_op, bit_compare_op, and_op, or_op, xor_op,
			add_carry_op, add_op, subtract_op, subtract_borrow_op};
		shrt = o inside {clear_op, increment_op, decrement_op, zero_negative_test_op,
			ones_complement_op, twos_complement_op, shift_left_logical_op,
			shift_right_logical_op, shift_right_arith_op, rotate_left_carry_op,
			rotate_right_carry_op, nibble_swap_op, absolute_jump_op, call_op};
		case (m)
			AM_INHERENT: return o <= nibble_swap_op;
			AM_REL_DIRECT, AM_REL_INDIRECT:
				return o inside {conditional_relative_jump_op, relative_call_op};
			AM_IMMEDIATE, AM_DIR_LONG, AM_IDX_LONG, AM_IND_LONG, AM_INDIDX_LONG: return full;
			default: return full | shrt;
		endcase
	endfunction : legal

	function automatic logic [1:0] follow(input cpuam_mode_type m);
		case (m)
			AM_INHERENT, AM_IDX_NONE: return 2'h0;
			AM_DIR_LONG, AM_IDX_LONG: return 2'h2;
			default: return 2'h1;
		endcase
	endfunction : follow

	function automatic logic [7:0] reads(input cpuam_mode_type m);
		case (m)
			AM_IND_SHORT, AM_INDIDX_SHORT, AM_REL_INDIRECT: return 8'h01;
			AM_IND_LONG, AM_INDIDX_LONG: return 8'h02;
			default: return 8'h00;
		endcase
	endfunction : reads

	function automatic logic [15:0] exp_ea(input cpuam_mode_type m,
		input logic [7:0] idx, b0, b1, m0, m1);
		case (m)
			AM_DIR_SHORT: return {8'h00, b0};
			AM_DIR_LONG: return {b0, b1};
			AM_IDX_NONE: return {8'h00, idx};
			AM_IDX_SHORT: return {8'h00, b0} + {8'h00, idx};
			AM_IDX_LONG: return {b0, b1} + {8'h00, idx};
			AM_IND_SHORT: return {8'h00, m0};
			AM_IND_LONG: return {m0, m1};
			AM_INDIDX_SHORT: return {8'h00, m0} + {8'h00, idx};
			default: return {m0, m1} + {8'h00, idx};
		endcase
	endfunction : exp_ea

	////////////////////////////////////////////////////////////////
	task automatic run(input cpuam_mode_type m, input cpuam_op_type o, input logic y,
		input logic [7:0] x, yv, b0, b1, input logic [15:0] pc);
		int         i;
		logic       ok;
		logic [7:0] m0, m1, off;
		ok = legal(m, o);
		m0 = mem_fn({8'h00, b0});
		m1 = mem_fn({8'h00, b0} + 16'h0001);
		@(negedge clk);
		mode_in = m;
		op_in = o;
		use_y = y;
		x_reg = x;
		y_reg = yv;
		next_pc = pc;
		nb = 8'h00;
		nr = 8'h00;
		start = 1'b1;
		for (i = 0; i < 200; i++) begin
			@(negedge clk);
			if (busy)
				start = 1'b0;
			if (done)
				break;
			// Random stalls on both sources and on the clock enable
			clk_en = ($random(seed) & 3) != 0;
			ibyte_valid = $random(seed);
			ibyte_data = (nb == 8'h00) ? b0 : ((nb == 8'h01) ? b1 : ~b1);
			mem_rvalid = mem_rd & $random(seed);
			mem_rdata = mem_rvalid ? mem_fn(mem_addr) : ~mem_fn(mem_addr);
		end
		if (i == 200) begin
			n_mismatch++;
			end_sim;
		end
		clk_en = 1'b1;
		ibyte_valid = 1'b0;
		mem_rvalid = 1'b0;
		if (ok && m == AM_INHERENT && o == set_irq_mask_op)
			exp_irq = IRQ_LEVEL_MASKED;
		if (ok && m == AM_INHERENT && o == clear_irq_mask_op)
			exp_irq = IRQ_LEVEL_OPEN;
		chk(illegal, !ok);
		chk(follow_len, ok ? follow(m) : 2'h0);
		chk(nb, ok ? 8'(follow(m)) : 8'h00);
		chk(nr, ok ? reads(m) : 8'h00);
		if (ok && reads(m) != 8'h00)
			chk(rd_addr[0], {8'h00, b0});
		if (ok && reads(m) == 8'h02)
			chk(rd_addr[1], {8'h00, b0} + 16'h0001);
		if (ok && !(m inside {AM_INHERENT, AM_IMMEDIATE, AM_REL_DIRECT, AM_REL_INDIRECT}))
			chk(eff_addr, exp_ea(m, y ? yv : x, b0, b1, m0, m1));
		if (ok && m == AM_IMMEDIATE)
			chk(imm_value, b0);
		off = (m == AM_REL_DIRECT) ? b0 : m0;
		if (ok && m inside {AM_REL_DIRECT, AM_REL_INDIRECT})
			chk(branch_target, pc + {{8{off[7]}}, off});
		chk(irq_level, exp_irq);
		chk(halt_pulse, ok && m == AM_INHERENT && o == halt_op);
		chk(wait_pulse, ok && m == AM_INHERENT && o == wait_for_interrupt_op);
		@(negedge clk);
		chk(done, 1'b0);
		chk(busy, 1'b0);
		ntest++;
		$display("test %0d mode %0d op %0d illegal %0b done", ntest, m, o, !ok);
	endtask : run

	////////////////////////////////////////////////////////////////
	initial begin
		int         k;
		logic [31:0] r, r2;
		seed = 72;
		clk = 1'b0;
		rstn = 1'b0;
		clk_en = 1'b1;
		start = 1'b0;
		mode_in = AM_INHERENT;
		op_in = nop_op;
		use_y = 1'b0;
		x_reg = 8'h00;
		y_reg = 8'h00;
		next_pc = 16'h0000;
		ibyte_valid = 1'b0;
		ibyte_data = 8'h00;
		mem_rvalid = 1'b0;
		mem_rdata = 8'h00;
		nb = 8'h00;
		nr = 8'h00;
		exp_irq = IRQ_LEVEL_RESET;
		repeat (3) @(posedge clk);
		@(negedge clk);
		rstn = 1'b1;
		chk(irq_level, IRQ_LEVEL_RESET);
		chk(busy, 1'b0);
		repeat (3) @(negedge clk);
		run(AM_IDX_SHORT, load_op, 1'b0, 8'hFF, 8'h00, 8'hFF, 8'h00, 16'h1000);
		run(AM_INDIDX_SHORT, add_op, 1'b1, 8'h00, 8'hFF, 8'h0F, 8'h00, 16'h1000);
		run(AM_IND_LONG, compare_op, 1'b0, 8'h00, 8'h00, 8'hFF, 8'h00, 16'h1000);
		run(AM_INDIDX_LONG, xor_op, 1'b1, 8'h11, 8'hC3, 8'h40, 8'h00, 16'h1000);
		run(AM_DIR_LONG, load_op, 1'b0, 8'h00, 8'h00, 8'h12, 8'h34, 16'h1000);
		run(AM_IDX_LONG, and_op, 1'b0, 8'hFF, 8'h00, 8'hFF, 8'hFF, 16'h1000);
		run(AM_IDX_NONE, clear_op, 1'b1, 8'h01, 8'hFF, 8'h00, 8'h00, 16'h1000);
		run(AM_DIR_SHORT, increment_op, 1'b0, 8'h00, 8'h00, 8'hFF, 8'h00, 16'h1000);
		run(AM_IND_SHORT, load_op, 1'b0, 8'h00, 8'h00, 8'h80, 8'h00, 16'h1000);
		run(AM_REL_DIRECT, conditional_relative_jump_op, 1'b0, 8'h00, 8'h00, 8'h80, 8'h00,
			16'h0010);
		run(AM_REL_INDIRECT, relative_call_op, 1'b0, 8'h00, 8'h00, 8'h23, 8'h00,
			16'hFFF0);
		run(AM_IMMEDIATE, subtract_borrow_op, 1'b0, 8'h00, 8'h00, 8'hA5, 8'h00, 16'h0);
		run(AM_IMMEDIATE, clear_op, 1'b0, 8'h00, 8'h00, 8'hA5, 8'h00, 16'h0);
		run(AM_DIR_LONG, increment_op, 1'b0, 8'h00, 8'h00, 8'h12, 8'h34, 16'h0);
		run(AM_REL_DIRECT, absolute_jump_op, 1'b0, 8'h00, 8'h00, 8'h05, 8'h00, 16'h0);
		for (k = 0; k <= 26; k++)
			run(AM_INHERENT, cpuam_op_type'(6'(k)), 1'b0, 8'h00, 8'h00, 8'h00, 8'h00,
				16'h0);
		run(AM_INHERENT, set_irq_mask_op, 1'b0, 8'h00, 8'h00, 8'h00, 8'h00, 16'h0);
		run(AM_INHERENT, clear_irq_mask_op, 1'b0, 8'h00, 8'h00, 8'h00, 8'h00, 16'h0);
		// Bit operation forms left out: their mode tables are not settled
		for (k = 0; k < 150; k++) begin
			r = $random(seed);
			r2 = $random(seed);
			if (((r[15:8] % 8'd44) >= 8'd36) && ((r[15:8] % 8'd44) <= 8'd39))
				r[15:8] = 8'h00;
			run(cpuam_mode_type'(4'(r[3:0] % 4'd13)), cpuam_op_type'(6'(r[15:8] % 8'd44)),
				r[4], r[23:16], r[31:24], r2[7:0], r2[15:8], r2[31:16]);
		end
		end_sim;
	end

endmodule : test_cpu_addressing_mode_decoder
